// File: hdl/acsc_top.sv
`timescale 1ns/1ps
// Functional notes
// (RQ1) setup register holds next conversion's configuration
// (RQ2) sequencer mode discards setup register writes
// (RQ3) bits 15:11 ignore writes, read zero
// (RQ4) bit 10 gates interrupt requests
// (RQ5) normal mode: request at settle end, conversion
// (RQ6) automatic mode: request only at conversion end
// (RQ7) pipeline off: result moves after conversion ends
// (RQ8) pipeline on: previous result moves during conversion
// (RQ9) normal mode: trigger write starts conversion
// (RQ10) host waits settling clear before trigger
// (RQ11) setup rewrite during conversion leaves it intact
// (RQ12) conversion pending clears only with valid result
// (RQ13) automatic mode: settle, then start by itself; a setup write made during a conversion never starts one
// (RQ14) gain code picks factor per build option
// (RQ15) reset clears all local registers to zero
// (RQ16) normal setup write sets settling pending
// (RQ17) conversion pending set by trigger or auto
// (RQ18) bit 5 differential, bits 4:0 channel
// (RQ19) gain table is a static build parameter
module acsc_top
  import acsc_pkg::*;
#(
  parameter bit GAIN_DECIMAL = 1'b1
)
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        seq_mode_en,
  output acsc_fe_t         fe_cfg,
  output logic      [3:0]  fe_gain_factor,
  output logic             fe_chan_ok,
  output logic             conv_start,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_data,
  output logic             irq_req
);

  acsc_setup_t setup_q;
  acsc_state_t state_q;
  logic [15:0] result_q;
  logic [15:0] held_q;
  logic        conv_busy_q;
  logic        pipe_run_q;
  logic        setup_wr;
  logic        trig_wr;
  logic        settle_restart;
  logic        settle_busy;
  logic        settle_done;
  logic        auto_go;
  logic [3:0]  gain_factor;
  logic        chan_ok;
  acsc_fe_t    fe_next;

  // write decodes; a setup write under sequencer mode never reaches the register
  assign setup_wr = reg_wr && reg_addr == OFS_SETUP && !seq_mode_en; // see RQ2
  // trigger only counts in normal mode and while no conversion runs
  assign trig_wr  = reg_wr && reg_addr == OFS_TRIGGER && !setup_q.auto_settle
                    && state_q == ST_IDLE; // see RQ9

  // any accepted setup write restarts settling, since the mux has moved
  assign settle_restart = setup_wr; // see RQ16
  assign auto_go        = state_q == ST_AUTO_SETTLE && settle_done; // see RQ13

  acsc_settle_timer u_settle (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .restart (settle_restart),
    .busy_q  (settle_busy),
    .done_q  (settle_done)
  );

  assign fe_next = '{gain:                setup_q.gain,
                     differential_select: setup_q.differential_select,
                     chan:                setup_q.chan};

  acsc_gain_map #(
    .GAIN_DECIMAL (GAIN_DECIMAL)
  ) u_gain (
    .cfg         (fe_next),
    .gain_factor (gain_factor),
    .chan_ok     (chan_ok)
  );

  // setup register; reserved bits are masked so they never store (see RQ3)
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      setup_q <= acsc_setup_t'(SETUP_RST); // see RQ15
    end else if (setup_wr) begin
      setup_q <= acsc_setup_t'(reg_wdata & SETUP_WR_MASK); // see RQ1
    end
  end

  // conversion sequencer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (setup_wr && reg_wdata[8]) begin
            state_q <= ST_AUTO_SETTLE; // see RQ13
          end else if (trig_wr) begin
            state_q <= ST_CONV; // see RQ9
          end
        end
        ST_AUTO_SETTLE: begin
          if (auto_go) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          // a setup write here moves the front end but not the state, so an automatic setup written now never starts a conversion
          if (conv_done) begin
            state_q <= ST_IDLE; // see RQ11
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // conversion start pulse and its pipeline mode, captured so that a
  // later setup write cannot change how the running result is handled
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      conv_start <= 1'b0;
      pipe_run_q <= 1'b0;
    end else begin
      conv_start <= trig_wr || auto_go;
      if (trig_wr || auto_go) begin
        pipe_run_q <= setup_q.pipelined_result_transfer; // see RQ11
      end
    end
  end

  // conversion pending flag: set by trigger or automatic setup write,
  // cleared only once the result register holds valid data
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      conv_busy_q <= 1'b0;
    end else if (trig_wr || (setup_wr && reg_wdata[8] && state_q == ST_IDLE)) begin
      conv_busy_q <= 1'b1; // see RQ17
    end else if (state_q == ST_CONV && conv_done) begin
      conv_busy_q <= 1'b0; // see RQ12
    end
  end

  // result path: direct after the end, or the previous value at the start
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      result_q <= 16'h0000;
      held_q   <= 16'h0000;
    end else begin
      if (conv_start && pipe_run_q) begin
        result_q <= held_q; // see RQ8
      end else if (state_q == ST_CONV && conv_done && !pipe_run_q) begin
        result_q <= conv_data; // see RQ7
      end
      if (state_q == ST_CONV && conv_done) begin
        held_q <= conv_data;
      end
    end
  end

  // interrupt request pulse; settle end counts only in normal mode
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= setup_q.irq_request_enable // see RQ4
                 && ((settle_done && !setup_q.auto_settle) // see RQ5
                     || (state_q == ST_CONV && conv_done)); // see RQ6
    end
  end

  // front-end drive follows the setup register so settling starts at once
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fe_cfg         <= '0;
      fe_gain_factor <= 4'h1;
      fe_chan_ok     <= 1'b1;
    end else begin
      fe_cfg         <= fe_next;
      fe_gain_factor <= gain_factor; // see RQ14
      fe_chan_ok     <= chan_ok; // see RQ18
    end
  end

  // read port: one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_SETUP:  reg_rdata <= 16'(setup_q) & SETUP_WR_MASK; // see RQ3
        OFS_RESULT: reg_rdata <= result_q;
        OFS_STATUS: begin
          reg_rdata                  <= 16'h0000;
          reg_rdata[STAT_CONV_BIT]   <= conv_busy_q;
          // host must see this low before triggering in normal mode
          reg_rdata[STAT_SETTLE_BIT] <= settle_busy; // see RQ10
        end
        default:    reg_rdata <= 16'h0000;
      endcase
    end
  end

endmodule // acsc_top

// File: hdl/acsc_pkg.sv
package acsc_pkg;

  // clock and settling timing
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned SETTLE_TIME_NS  = 10000;
  localparam int unsigned SETTLE_CYC      = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] SETTLE_CYC_W    = 16'(SETTLE_CYC);

  // local register offsets (byte offsets in the 256-byte register space)
  localparam logic [7:0]  OFS_SETUP       = 8'h00;
  localparam logic [7:0]  OFS_RESULT      = 8'h02;
  localparam logic [7:0]  OFS_STATUS      = 8'h04;
  localparam logic [7:0]  OFS_TRIGGER     = 8'h06;

  // setup register: reset value and writable bits
  localparam logic [15:0] SETUP_RST       = 16'h0000;
  localparam logic [15:0] SETUP_WR_MASK   = 16'h07FF;

  // status register bit positions
  localparam int unsigned STAT_CONV_BIT   = 0;
  localparam int unsigned STAT_SETTLE_BIT = 1;

  // highest channel usable in differential mode
  localparam logic [4:0]  DIFF_CHAN_MAX   = 5'h0F;

  typedef struct packed {
    logic [4:0] rsvd;
    logic       irq_request_enable;
    logic       pipelined_result_transfer;
    logic       auto_settle;
    logic [1:0] gain;
    logic       differential_select;
    logic [4:0] chan;
  } acsc_setup_t;

  typedef struct packed {
    logic [1:0] gain;
    logic       differential_select;
    logic [4:0] chan;
  } acsc_fe_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_AUTO_SETTLE,
    ST_CONV
  } acsc_state_t;

endpackage

// File: hdl/acsc_settle_timer.sv
`timescale 1ns/1ps
// settling timer: a restart reloads the count, so the last setup write wins
module acsc_settle_timer
  import acsc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic restart,
  output logic      busy_q,
  output logic      done_q
);

  logic [15:0] cnt_q;

  // count down from the settling figure; done is a one-cycle pulse
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_q  <= 16'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (restart) begin
      cnt_q  <= SETTLE_CYC_W - 16'h0001;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end else if (busy_q && cnt_q == 16'h0000) begin
      busy_q <= 1'b0;
      done_q <= 1'b1;
    end else begin
      cnt_q  <= busy_q ? cnt_q - 16'h0001 : cnt_q;
      done_q <= 1'b0;
    end
  end

endmodule // acsc_settle_timer

// File: hdl/acsc_gain_map.sv
`timescale 1ns/1ps
// gain code to amplifier factor, and channel legality for the input mode
module acsc_gain_map
  import acsc_pkg::*;
#(
  parameter bit GAIN_DECIMAL = 1'b1
)
(
  input  acsc_fe_t   cfg,
  output logic [3:0] gain_factor,
  output logic       chan_ok
);

  // build option is a static parameter, never a software setting (see RQ19)
  always_comb begin
    case (cfg.gain) // see RQ14
      2'b00:   gain_factor = 4'h1;
      2'b01:   gain_factor = 4'h2;
      2'b10:   gain_factor = GAIN_DECIMAL ? 4'h5 : 4'h4;
      2'b11:   gain_factor = GAIN_DECIMAL ? 4'hA : 4'h8;
      default: gain_factor = 4'h1;
    endcase
  end

  // differential pairs exist only on the lower sixteen channels
  assign chan_ok = !cfg.differential_select || (cfg.chan <= DIFF_CHAN_MAX); // see RQ18

endmodule // acsc_gain_map

// File: tb/acsc_sva.sv
`timescale 1ns/1ps
module acsc_sva
  import acsc_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        seq_mode_en,
  input wire acsc_fe_t    fe_cfg,
  input wire logic        conv_start,
  input wire logic        conv_done,
  input wire logic        irq_req
);
  logic [15:0] setup_q;
  logic        ien_q;
  logic        trig_q;
  logic        sw;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // shadow copy, since the gating bits are not visible at the ports
  assign sw = reg_wr && reg_addr == OFS_SETUP && !seq_mode_en;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) setup_q <= 16'h0000;
    else if (sw) setup_q <= reg_wdata & SETUP_WR_MASK;
  end
  // delayed copies keep $past to plain signals
  always_ff @(posedge sys_clk) begin
    ien_q  <= setup_q[10];
    trig_q <= reg_wr && reg_addr == OFS_TRIGGER;
  end
  property p_rsvd; reg_rd && reg_addr == OFS_SETUP |=> reg_rdata[15:11] == 5'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
  property p_seq; reg_wr && reg_addr == OFS_SETUP && seq_mode_en |=> $stable(fe_cfg); endproperty
  a_seq: assert property (p_seq) else $error("setup changed in sequencer mode");
  // front-end copy is registered from the setup register, so it lags the write by two edges
  property p_cfg; sw |=> ##1 fe_cfg == setup_q[7:0]; endproperty
  a_cfg: assert property (p_cfg) else $error("front end setup mismatch");
  property p_irq_off; !setup_q[10] && !ien_q |-> !irq_req; endproperty
  a_irq_off: assert property (p_irq_off) else $error("request while disabled");
  property p_start; $rose(conv_start) |-> trig_q || setup_q[8]; endproperty
  a_start: assert property (p_start) else $error("start without trigger");
  property p_done; conv_done && setup_q[10] |=> irq_req; endproperty
  a_done: assert property (p_done) else $error("no request at conversion end");
  property p_settle; sw && reg_wdata[10] && !reg_wdata[8] |-> ##[245:255] irq_req; endproperty
  a_settle: assert property (p_settle) else $error("no request at settle end");
  property p_auto; sw && reg_wdata[8] |-> ##[245:255] conv_start; endproperty
  a_auto: assert property (p_auto) else $error("automatic start missing");
  property p_auto_q; conv_start && setup_q[8] |-> !irq_req ##1 !irq_req; endproperty
  a_auto_q: assert property (p_auto_q) else $error("request at automatic settle");
  c_conv: cover property (conv_done ##1 irq_req);
  c_seq: cover property (seq_mode_en && reg_wr);
  c_auto: cover property (conv_start && setup_q[8]);
endmodule // acsc_sva

bind acsc_top acsc_sva i_acsc_sva (.sys_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata, .seq_mode_en, .fe_cfg, .conv_start, .conv_done, .irq_req);

// File: tb/acsc_conv_model.sv
`timescale 1ns/1ps
// converter stand-in: a start is answered after a fixed delay
module acsc_conv_model
  import acsc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        conv_start,
  output logic             conv_done,
  output logic      [15:0] conv_data
);
  logic [4:0]  cnt_q = 5'h00;
  logic [15:0] val_q = 16'h1234;
  initial conv_done = 1'b0;
  initial conv_data = 16'h0000;
  // data toggles outside the done pulse so a stale sample never matches
  always @(posedge sys_clk) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (conv_start) cnt_q <= 5'h14;
    else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
    if (cnt_q == 5'h01) begin
      conv_done <= 1'b1;
      conv_data <= val_q;
      val_q     <= val_q + 16'h1111;
    end
  end
endmodule // acsc_conv_model

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench import acsc_pkg::*;;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        seq_mode_en = 1'b0;
  logic [15:0] reg_rdata;
  acsc_fe_t    fe_cfg;
  logic [3:0]  fe_gain_factor;
  logic        fe_chan_ok;
  logic        conv_start;
  logic        conv_done;
  logic [15:0] conv_data;
  logic        irq_req;
  int          miscompares = 0;
  int          cmp_count = 0;
  always #20 sys_clk = ~sys_clk;
  acsc_top #(.GAIN_DECIMAL(1'b1)) i_acsc_top (.sys_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .seq_mode_en, .fe_cfg, .fe_gain_factor, .fe_chan_ok, .conv_start,
    .conv_done, .conv_data, .irq_req);
  acsc_conv_model i_acsc_conv_model (.sys_clk, .conv_start, .conv_done, .conv_data);
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  // one-cycle strobe, released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data is sampled a full cycle late; it holds until the next read
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(reg_rdata, e);
  endtask
  // bounded wait for one request pulse; a missing pulse ends the run
  task automatic wirq(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge sys_clk);
      #1;
      if (irq_req === 1'b1) break;
    end
    if (i == n) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic s_gain();
    logic [3:0] f [4] = '{4'h1, 4'h2, 4'h5, 4'hA};
    for (int g = 0; g < 4; g++) begin
      wr(OFS_SETUP, {8'h00, 2'(g), 6'h2F});
      repeat (2) @(posedge sys_clk);
      #1;
      chk({12'h000, fe_gain_factor}, {12'h000, f[g]});
      chk({8'h00, fe_cfg}, {8'h00, 2'(g), 6'h2F});
    end
    wr(OFS_SETUP, 16'h0030);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({15'h0000, fe_chan_ok}, 16'h0000);
  endtask
  task automatic s_setup();
    wr(OFS_SETUP, 16'hFEFF);
    rd(OFS_SETUP, 16'h06FF);
    rd(OFS_STATUS, 16'h0002);
    wirq(300);
    rd(OFS_STATUS, 16'h0000);
    @(posedge sys_clk);
    seq_mode_en <= 1'b1;
    wr(OFS_SETUP, 16'h0000);
    rd(OFS_SETUP, 16'h06FF);
    seq_mode_en <= 1'b0;
  endtask
  task automatic s_conv();
    wr(OFS_SETUP, 16'h0403);
    wirq(300);
    rd(OFS_STATUS, 16'h0000);
    wr(OFS_TRIGGER, 16'h0000);
    rd(OFS_STATUS, 16'h0001);
    wr(OFS_SETUP, 16'h0405);
    wirq(100);
    rd(OFS_RESULT, 16'h1234);
    rd(OFS_STATUS, 16'h0002);
    wirq(300);
  endtask
  task automatic s_pipe();
    wr(OFS_SETUP, 16'h0600);
    wirq(300);
    wr(OFS_TRIGGER, 16'h0000);
    wirq(100);
    rd(OFS_RESULT, 16'h1234);
    wr(OFS_TRIGGER, 16'h0000);
    wirq(100);
    rd(OFS_RESULT, 16'h2345);
  endtask
  task automatic s_auto();
    wr(OFS_SETUP, 16'h0500);
    // settling bit still runs in automatic mode; it carries no meaning there
    rd(OFS_STATUS, 16'h0003);
    wirq(400);
    rd(OFS_STATUS, 16'h0000);
    rd(OFS_RESULT, 16'h4567);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(OFS_SETUP, 16'h0000);
    rd(OFS_STATUS, 16'h0000);
    rd(8'h10, 16'h0000);
    s_gain();
    s_setup();
    s_conv();
    s_pipe();
    s_auto();
    complete_run();
  end
endmodule // testbench
